// *** hdl/ivdec_decoder.sv ***
// top of the isa variant decoder: classifies implementation-specific ops
`default_nettype none
module ivdec_decoder
	import ivdec_pkg::*;
(
	input  wire logic        i_clk,
	input  wire logic        i_rst_n,
	input  wire logic        i_valid,
	input  wire logic [31:0] i_instr,
	input  wire logic [63:0] i_vaddr,
	input  wire logic        i_sys_coproc_usable_bit,
	input  wire logic        i_mem_idle,
	input  wire logic        i_branch_taken,
	output logic             o_ready,
	output logic             o_valid,
	output var ivdec_kind_t  o_kind,
	output logic             o_resv_exc,
	output logic             o_cop_unusable,
	output var ivdec_cop_t   o_cop_sel,
	output logic             o_cache_req,
	output var ivdec_target_t o_cache_target,
	output var ivdec_action_t o_cache_action,
	output logic [1:0]       o_cache_way,
	output logic [63:0]      o_cache_addr,
	output logic             o_barrier,
	output logic [4:0]       o_src_reg,
	output logic [4:0]       o_dst_reg,
	output logic             o_delay_slot,
	output logic             o_annul
);

	////////////////////////////////////////////////////////////////////////
	// state layout
	typedef struct packed {
		logic                ready;
		logic                valid;
		ivdec_kind_t         kind;
		logic                resv_exc;
		logic                cop_unusable;
		ivdec_cop_t          cop_sel;
		logic                cache_req;
		ivdec_target_t       cache_target;
		ivdec_action_t       cache_action;
		logic [WAY_BITS-1:0] cache_way;
		logic [63:0]         cache_addr;
		logic                barrier;
		logic [4:0]          src_reg;
		logic [4:0]          dst_reg;
		logic                delay_slot;
		logic                annul;
		logic                slot_pending;
		logic                slot_likely;
	} ivdec_st_t;

	localparam ivdec_st_t ST_RESET = '{
		ready:        RST_READY,
		kind:         KIND_PASS,
		cop_sel:      COP_NONE,
		cache_target: TGT_NONE,
		cache_action: ACT_NONE,
		default:      '0
	};

	ivdec_st_t  st_r;
	ivdec_st_t  st_nxt;
	logic [1:0] rst_sync_r;
	logic       rst_n;

	ivdec_core_if cif ();

	////////////////////////////////////////////////////////////////////////
	// reset release through two flops, assertion stays asynchronous
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			rst_sync_r <= 2'h0;
		else
			rst_sync_r <= {rst_sync_r[0], 1'b1};
	end

	assign rst_n = rst_sync_r[1];

	////////////////////////////////////////////////////////////////////////
	// helper units
	ivdec_cache_map u_cache_map (
		.cif (cif.map)
	);

	ivdec_barrier u_barrier (
		.i_clk   (i_clk),
		.i_rst_n (rst_n),
		.cif     (cif.drain)
	);

	////////////////////////////////////////////////////////////////////////
	// field extraction
	logic [5:0] opc;
	logic [4:0] rs;
	logic [4:0] rt;
	logic [4:0] rd;
	logic [4:0] sa;
	logic [5:0] fn;
	logic       take;
	logic       annul_c;
	logic       sync_start_c;

	assign opc  = i_instr[OPC_LSB +: 6];
	assign rs   = i_instr[RS_LSB +: 5];
	assign rt   = i_instr[RT_LSB +: 5];
	assign rd   = i_instr[RD_LSB +: 5];
	assign sa   = i_instr[SA_LSB +: 5];
	assign fn   = i_instr[5:0];
	assign take = i_valid && st_r.ready;

	// an untaken likely branch kills its slot before anything else acts
	assign annul_c = st_r.slot_pending && st_r.slot_likely
		&& !i_branch_taken;

	assign cif.cache_op   = rt;
	assign cif.mem_idle   = i_mem_idle;
	assign cif.sync_start = sync_start_c;

	////////////////////////////////////////////////////////////////////////
	// main decode
	always_comb
	begin
		st_nxt       = st_r;
		sync_start_c = 1'b0;
		// one-cycle result flags
		st_nxt.valid        = 1'b0;
		st_nxt.resv_exc     = 1'b0;
		st_nxt.cop_unusable = 1'b0;
		st_nxt.cache_req    = 1'b0;
		st_nxt.barrier      = 1'b0;
		st_nxt.annul        = 1'b0;
		if (take)
		begin
			st_nxt.valid        = 1'b1;
			st_nxt.kind         = KIND_PASS;
			st_nxt.cop_sel      = COP_NONE;
			st_nxt.cache_target = TGT_NONE;
			st_nxt.cache_action = ACT_NONE;
			st_nxt.cache_way    = '0;
			st_nxt.cache_addr   = i_vaddr;
			st_nxt.src_reg      = rt;
			st_nxt.dst_reg      = rd;
			st_nxt.delay_slot   = st_r.slot_pending;
			st_nxt.slot_pending = 1'b0;
			st_nxt.slot_likely  = 1'b0;
			if (annul_c)
			begin
				st_nxt.kind  = KIND_NOP;
				st_nxt.annul = 1'b1;
			end
			else
			begin
				case (opc)
					OPC_SPECIAL:
						case (fn)
							FN_SLL:
								// plain nop, superscalar_noop_instr and ehb: all plain no-ops, none stalls
								if (rs == 5'h00 && rt == 5'h00
									&& rd == 5'h00
									&& (sa == 5'h00 || sa == SA_SUPERSCALAR_NOOP_INSTR
									|| sa == SA_EHB))
									st_nxt.kind = KIND_NOP;
							FN_SYNC:
								if (sa != SYNC_STYPE_OK)
								begin
									st_nxt.kind     = KIND_EXC;
									st_nxt.resv_exc = 1'b1;
								end
								else if (!i_sys_coproc_usable_bit)
								begin
									st_nxt.kind         = KIND_EXC;
									st_nxt.cop_unusable = 1'b1;
								end
								else
								begin
									st_nxt.kind    = KIND_BARRIER;
									st_nxt.barrier = 1'b1;
									sync_start_c   = 1'b1;
								end
							FN_JR, FN_JALR:
							begin
								st_nxt.kind         = KIND_BRANCH;
								st_nxt.slot_pending = 1'b1;
							end
							default: st_nxt.kind = KIND_PASS;
						endcase
					OPC_REGIMM:
						// traps share this opcode; only branches get slots
						if (rt[3:2] == 2'b00)
						begin
							st_nxt.kind         = KIND_BRANCH;
							st_nxt.slot_pending = 1'b1;
							st_nxt.slot_likely  = rt[1];
						end
					OPC_J, OPC_JAL, OPC_BEQ, OPC_BNE, OPC_BLEZ, OPC_BGTZ:
					begin
						st_nxt.kind         = KIND_BRANCH;
						st_nxt.slot_pending = 1'b1;
					end
					OPC_BEQL, OPC_BNEL, OPC_BLEZL, OPC_BGTZL:
					begin
						st_nxt.kind         = KIND_BRANCH;
						st_nxt.slot_pending = 1'b1;
						st_nxt.slot_likely  = 1'b1;
					end
					OPC_PREFETCH_HINT_INSTR:
						st_nxt.kind = KIND_NOP;
					OPC_COP1X:
						if (fn == FN_INDEXED_PREFETCH_HINT_INSTR)
							st_nxt.kind = KIND_NOP;
						else
						begin
							st_nxt.kind    = KIND_COP;
							st_nxt.cop_sel = COP_FLOAT;
						end
					OPC_COP1:
					begin
						st_nxt.kind    = KIND_COP;
						st_nxt.cop_sel = COP_FLOAT;
					end
					OPC_COP0:
					begin
						st_nxt.kind    = KIND_COP;
						st_nxt.cop_sel = COP_SYS;
						if (i_instr[CO_BIT] && fn == FN_WAIT)
							st_nxt.kind = KIND_NOP;
						else if (!i_instr[CO_BIT]
							&& (rs == RS_READ_PREV_REGSET_INSTR || rs == RS_WRITE_PREV_REGSET_INSTR))
							// no shadow sets: plain move in current set
							st_nxt.kind = KIND_REGMOVE;
						else if (!i_instr[CO_BIT] && rs == RS_MFMC0)
						begin
							st_nxt.kind     = KIND_EXC;
							st_nxt.resv_exc = 1'b1;
						end
					end
					OPC_CACHE:
						if (cif.cache_ok)
						begin
							st_nxt.kind         = KIND_CACHE;
							st_nxt.cache_req    = 1'b1;
							st_nxt.cache_target = cif.cache_target;
							st_nxt.cache_action = cif.cache_action;
							if (cif.cache_action != ACT_HIT_INV
								&& cif.cache_action != ACT_HIT_WB_INV)
								st_nxt.cache_way =
									i_vaddr[WAY_BITS-1:0];
						end
						else
						begin
							st_nxt.kind     = KIND_EXC;
							st_nxt.resv_exc = 1'b1;
						end
					default: st_nxt.kind = KIND_PASS;
				endcase
			end
		end
		// later accesses wait while earlier ones drain
		st_nxt.ready = !sync_start_c
			&& !(cif.sync_busy && !i_mem_idle);
	end

	////////////////////////////////////////////////////////////////////////
	// state register on the released reset
	always_ff @(posedge i_clk or negedge rst_n)
	begin
		if (!rst_n)
			st_r <= ST_RESET;
		else
			st_r <= st_nxt;
	end

	////////////////////////////////////////////////////////////////////////
	// outputs straight from the state flops
	assign o_ready        = st_r.ready;
	assign o_valid        = st_r.valid;
	assign o_kind         = st_r.kind;
	assign o_resv_exc     = st_r.resv_exc;
	assign o_cop_unusable = st_r.cop_unusable;
	assign o_cop_sel      = st_r.cop_sel;
	assign o_cache_req    = st_r.cache_req;
	assign o_cache_target = st_r.cache_target;
	assign o_cache_action = st_r.cache_action;
	assign o_cache_way    = st_r.cache_way;
	assign o_cache_addr   = st_r.cache_addr;
	assign o_barrier      = st_r.barrier;
	assign o_src_reg      = st_r.src_reg;
	assign o_dst_reg      = st_r.dst_reg;
	assign o_delay_slot   = st_r.delay_slot;
	assign o_annul        = st_r.annul;

endmodule : ivdec_decoder
`default_nettype wire

// *** hdl/ivdec_pkg.sv ***
// constants and types shared by the isa variant decoder
`default_nettype none
package ivdec_pkg;

	////////////////////////////////////////////////////////////////////////
	// instruction field positions
	localparam int OPC_LSB = 26;
	localparam int RS_LSB  = 21;
	localparam int RT_LSB  = 16;
	localparam int RD_LSB  = 11;
	localparam int SA_LSB  = 6;
	localparam int CO_BIT  = 25;
	localparam int WAY_BITS = 2;

	////////////////////////////////////////////////////////////////////////
	// major opcodes
	localparam logic [5:0] OPC_SPECIAL = 6'h00;
	localparam logic [5:0] OPC_REGIMM  = 6'h01;
	localparam logic [5:0] OPC_J       = 6'h02;
	localparam logic [5:0] OPC_JAL     = 6'h03;
	localparam logic [5:0] OPC_BEQ     = 6'h04;
	localparam logic [5:0] OPC_BNE     = 6'h05;
	localparam logic [5:0] OPC_BLEZ    = 6'h06;
	localparam logic [5:0] OPC_BGTZ    = 6'h07;
	localparam logic [5:0] OPC_COP0    = 6'h10;
	localparam logic [5:0] OPC_COP1    = 6'h11;
	localparam logic [5:0] OPC_COP1X   = 6'h13;
	localparam logic [5:0] OPC_BEQL    = 6'h14;
	localparam logic [5:0] OPC_BNEL    = 6'h15;
	localparam logic [5:0] OPC_BLEZL   = 6'h16;
	localparam logic [5:0] OPC_BGTZL   = 6'h17;
	localparam logic [5:0] OPC_CACHE   = 6'h2f;
	localparam logic [5:0] OPC_PREFETCH_HINT_INSTR    = 6'h33;

	// function, shift and sub-op codes
	localparam logic [5:0] FN_SLL   = 6'h00;
	localparam logic [5:0] FN_JR    = 6'h08;
	localparam logic [5:0] FN_JALR  = 6'h09;
	localparam logic [5:0] FN_SYNC  = 6'h0f;
	localparam logic [5:0] FN_INDEXED_PREFETCH_HINT_INSTR = 6'h0f;
	localparam logic [5:0] FN_WAIT  = 6'h20;
	localparam logic [4:0] SA_SUPERSCALAR_NOOP_INSTR = 5'h01;
	localparam logic [4:0] SA_EHB   = 5'h03;
	localparam logic [4:0] RS_READ_PREV_REGSET_INSTR = 5'h0a;
	localparam logic [4:0] RS_MFMC0  = 5'h0b;
	localparam logic [4:0] RS_WRITE_PREV_REGSET_INSTR = 5'h0e;
	localparam logic [4:0] SYNC_STYPE_OK = 5'h00;

	////////////////////////////////////////////////////////////////////////
	// effective cache operation codes
	localparam logic [4:0] CO_I_IDX_INV     = 5'h00;
	localparam logic [4:0] CO_I_IDX_ST_TAG  = 5'h08;
	localparam logic [4:0] CO_D_IDX_WB_INV  = 5'h01;
	localparam logic [4:0] CO_D_IDX_LD_TAG  = 5'h05;
	localparam logic [4:0] CO_D_IDX_ST_TAG  = 5'h09;
	localparam logic [4:0] CO_D_HIT_INV     = 5'h11;
	localparam logic [4:0] CO_D_HIT_WB_INV  = 5'h15;
	localparam logic [4:0] CO_D_IDX_LD_DATA = 5'h19;
	localparam logic [4:0] CO_S_IDX_WB_INV  = 5'h03;
	localparam logic [4:0] CO_S_IDX_LD_TAG  = 5'h07;
	localparam logic [4:0] CO_S_IDX_ST_TAG  = 5'h0b;
	localparam logic [4:0] CO_S_HIT_WB_INV  = 5'h13;
	localparam logic [4:0] CO_S_IDX_LD_DATA = 5'h1b;
	localparam logic [2:0] CO_ST_DATA_CLASS = 3'h7;
	localparam logic [1:0] CO_SEL_I = 2'h0;
	localparam logic [1:0] CO_SEL_D = 2'h1;
	localparam logic [1:0] CO_SEL_S = 2'h3;

	// values after reset
	localparam logic RST_READY = 1'b1;

	////////////////////////////////////////////////////////////////////////
	// enumerations
	typedef enum logic [2:0] {
		KIND_PASS, KIND_NOP, KIND_BARRIER, KIND_CACHE,
		KIND_REGMOVE, KIND_COP, KIND_BRANCH, KIND_EXC
	} ivdec_kind_t;

	typedef enum logic [1:0] {
		COP_NONE, COP_SYS, COP_FLOAT
	} ivdec_cop_t;

	typedef enum logic [1:0] {
		TGT_NONE, TGT_I, TGT_D, TGT_S
	} ivdec_target_t;

	typedef enum logic [3:0] {
		ACT_NONE, ACT_IDX_INV, ACT_IDX_WB_INV, ACT_IDX_LD_TAG,
		ACT_IDX_ST_TAG, ACT_HIT_INV, ACT_HIT_WB_INV,
		ACT_IDX_LD_DATA, ACT_IDX_ST_DATA
	} ivdec_action_t;

	typedef enum logic {
		DRAIN_IDLE, DRAIN_WAIT
	} ivdec_drain_t;

endpackage : ivdec_pkg
`default_nettype wire

// *** hdl/ivdec_core_if.sv ***
// carrier between the decoder core and its cache map and drain units
`default_nettype none
interface ivdec_core_if
	import ivdec_pkg::*;
();
	logic [4:0]    cache_op;
	ivdec_target_t cache_target;
	ivdec_action_t cache_action;
	logic          cache_ok;
	logic          sync_start;
	logic          mem_idle;
	logic          sync_busy;

	modport map   (input cache_op, output cache_target, cache_action,
		cache_ok);
	modport drain (input sync_start, mem_idle, output sync_busy);
	modport core  (output cache_op, sync_start, mem_idle,
		input cache_target, cache_action, cache_ok, sync_busy);
endinterface : ivdec_core_if
`default_nettype wire

// *** hdl/ivdec_cache_map.sv ***
// maps the cache operation code onto target cache and action
`default_nettype none
module ivdec_cache_map
	import ivdec_pkg::*;
(
	ivdec_core_if.map cif
);

	////////////////////////////////////////////////////////////////////////
	// pure decode, no state
	always_comb
	begin
		cif.cache_target = TGT_NONE;
		cif.cache_action = ACT_NONE;
		cif.cache_ok     = 1'b1;
		if (cif.cache_op[4:2] == CO_ST_DATA_CLASS)
		begin
			// never lock: class 111 is store data by index, except select 2'h2, which is refused
			cif.cache_action = ACT_IDX_ST_DATA;
			case (cif.cache_op[1:0])
				CO_SEL_I: cif.cache_target = TGT_I;
				CO_SEL_D: cif.cache_target = TGT_D;
				CO_SEL_S: cif.cache_target = TGT_S;
				default:  cif.cache_ok = 1'b0;
			endcase
		end
		else
		begin
			case (cif.cache_op)
				CO_I_IDX_INV:
				begin
					cif.cache_target = TGT_I;
					cif.cache_action = ACT_IDX_INV;
				end
				CO_I_IDX_ST_TAG:
				begin
					cif.cache_target = TGT_I;
					cif.cache_action = ACT_IDX_ST_TAG;
				end
				CO_D_IDX_WB_INV:
				begin
					cif.cache_target = TGT_D;
					cif.cache_action = ACT_IDX_WB_INV;
				end
				CO_D_IDX_LD_TAG:
				begin
					cif.cache_target = TGT_D;
					cif.cache_action = ACT_IDX_LD_TAG;
				end
				CO_D_IDX_ST_TAG:
				begin
					cif.cache_target = TGT_D;
					cif.cache_action = ACT_IDX_ST_TAG;
				end
				CO_D_HIT_INV:
				begin
					cif.cache_target = TGT_D;
					cif.cache_action = ACT_HIT_INV;
				end
				CO_D_HIT_WB_INV:
				begin
					cif.cache_target = TGT_D;
					cif.cache_action = ACT_HIT_WB_INV;
				end
				CO_D_IDX_LD_DATA:
				begin
					cif.cache_target = TGT_D;
					cif.cache_action = ACT_IDX_LD_DATA;
				end
				CO_S_IDX_WB_INV:
				begin
					cif.cache_target = TGT_S;
					cif.cache_action = ACT_IDX_WB_INV;
				end
				CO_S_IDX_LD_TAG:
				begin
					cif.cache_target = TGT_S;
					cif.cache_action = ACT_IDX_LD_TAG;
				end
				CO_S_IDX_ST_TAG:
				begin
					cif.cache_target = TGT_S;
					cif.cache_action = ACT_IDX_ST_TAG;
				end
				CO_S_HIT_WB_INV:
				begin
					cif.cache_target = TGT_S;
					cif.cache_action = ACT_HIT_WB_INV;
				end
				CO_S_IDX_LD_DATA:
				begin
					cif.cache_target = TGT_S;
					cif.cache_action = ACT_IDX_LD_DATA;
				end
				default: cif.cache_ok = 1'b0;
			endcase
		end
	end

endmodule : ivdec_cache_map
`default_nettype wire

// *** hdl/ivdec_barrier.sv ***
// memory barrier drain tracker: busy until earlier accesses complete
`default_nettype none
module ivdec_barrier
	import ivdec_pkg::*;
(
	input  wire logic   i_clk,
	input  wire logic   i_rst_n,
	ivdec_core_if.drain cif
);

	typedef struct packed {
		ivdec_drain_t phase;
	} ivdec_bar_st_t;

	ivdec_bar_st_t st_r;
	ivdec_bar_st_t st_nxt;

	////////////////////////////////////////////////////////////////////////
	// next phase: wait for the memory side to report everything retired
	always_comb
	begin
		st_nxt = st_r;
		case (st_r.phase)
			DRAIN_IDLE:
				if (cif.sync_start)
					st_nxt.phase = DRAIN_WAIT;
			DRAIN_WAIT:
				if (cif.mem_idle)
					st_nxt.phase = DRAIN_IDLE;
			default: st_nxt.phase = DRAIN_IDLE;
		endcase
	end

	// state register
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			st_r <= '{phase: DRAIN_IDLE};
		else
			st_r <= st_nxt;
	end

	// always at least one busy cycle, even if memory is already idle
	assign cif.sync_busy = (st_r.phase == DRAIN_WAIT);

endmodule : ivdec_barrier
`default_nettype wire

// *** bench/ivdec_props.sv ***
// concurrent checks on the ports of the isa variant decoder
`default_nettype none
module ivdec_props
	import ivdec_pkg::*;
(
	input wire logic		i_clk,
	input wire logic		i_rst_n,
	input wire logic		i_valid,
	input wire logic [31:0]	i_instr,
	input wire logic [63:0]	i_vaddr,
	input wire logic		i_sys_coproc_usable_bit,
	input wire logic		i_mem_idle,
	input wire logic		o_ready,
	input wire logic		o_valid,
	input var ivdec_kind_t	o_kind,
	input wire logic		o_resv_exc,
	input wire logic		o_cop_unusable,
	input wire logic		o_cache_req,
	input var ivdec_action_t	o_cache_action,
	input wire logic [1:0]	o_cache_way,
	input wire logic		o_barrier,
	input wire logic [4:0]	o_src_reg,
	input wire logic [4:0]	o_dst_reg,
	input wire logic		o_delay_slot,
	input wire logic		o_annul
);
	timeunit 1ns;
	timeprecision 100ps;

	////////////////////////////////////////////////////////////////////////
	// decoder is deaf for two edges after release; skip the first three edges
	logic [1:0] live_r;
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			live_r <= 2'h0;
		else if (live_r != 2'h3)
			live_r <= live_r + 2'h1;
	end
	// request decode at the taking edge
	wire logic take = i_valid && o_ready && live_r == 2'h3;
	wire logic cop0 = take && i_instr[31:26] == OPC_COP0;
	wire logic is_sync = take && i_instr[31:26] == OPC_SPECIAL
		&& i_instr[5:0] == FN_SYNC;
	wire logic stype_ok = i_instr[10:6] == SYNC_STYPE_OK;
	wire logic is_cache = take && i_instr[31:26] == OPC_CACHE;

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	a_answer_next: assert property (take |=> o_valid)
		else $error("accepted instruction got no answer");
	a_prefetch_nop: assert property (
		take && i_instr[31:26] == OPC_PREFETCH_HINT_INSTR
		|=> o_kind == KIND_NOP && !o_cache_req)
		else $error("prefetch did not complete as no-op");
	a_wait_no_stall: assert property (
		cop0 && i_instr[CO_BIT] && i_instr[5:0] == FN_WAIT
		|=> o_kind == KIND_NOP && o_ready ##1 (o_ready || o_barrier))
		else $error("wait stalled or was not a no-op");
	a_prev_regset: assert property (
		cop0 && (i_instr[25:21] == RS_READ_PREV_REGSET_INSTR || i_instr[25:21] == RS_WRITE_PREV_REGSET_INSTR)
		|=> o_annul || o_kind == KIND_REGMOVE
		&& o_src_reg == $past(i_instr[20:16])
		&& o_dst_reg == $past(i_instr[15:11]))
		else $error("register move not on current set");
	a_sync_stype_bad: assert property (
		is_sync && !stype_ok
		|=> o_annul
		|| o_resv_exc && o_kind == KIND_EXC && !o_barrier)
		else $error("bad barrier subtype not refused");
	a_sync_stall: assert property (
		is_sync && stype_ok && i_sys_coproc_usable_bit
		|=> o_annul || o_barrier && !o_ready)
		else $error("barrier did not block later requests");
	a_stall_holds: assert property (
		!o_ready && !i_mem_idle |=> !o_ready)
		else $error("ready rose before memory drained");
	a_stall_ends: assert property (
		!o_ready && i_mem_idle |=> o_ready)
		else $error("ready stayed low after drain");
	a_sync_kernel: assert property (
		is_sync && stype_ok && !i_sys_coproc_usable_bit
		|=> o_annul || o_cop_unusable && !o_barrier && o_ready)
		else $error("barrier outside kernel not refused");
	a_way_low_bits: assert property (
		o_cache_req && o_cache_action != ACT_HIT_INV
		&& o_cache_action != ACT_HIT_WB_INV
		|-> o_cache_way == $past(i_vaddr[1:0]))
		else $error("index way not from low address bits");
	a_store_data_class: assert property (
		is_cache && i_instr[20:18] == CO_ST_DATA_CLASS
		&& i_instr[17:16] != 2'h2
		|=> o_annul
		|| o_cache_req && o_cache_action == ACT_IDX_ST_DATA)
		else $error("class 111 not index store data");
	a_intr_refused: assert property (
		cop0 && i_instr[25:21] == RS_MFMC0
		|=> o_annul || o_resv_exc && !o_cache_req)
		else $error("interrupt enable or disable not refused");
	a_annul_slot: assert property (
		o_annul |-> o_valid && o_delay_slot && o_kind == KIND_NOP)
		else $error("annulled slot not a no-op slot");

	// main scenarios reached
	c_barrier_stall: cover property (o_barrier ##1 !o_ready);
	c_annul: cover property (o_annul);
	c_hit_op: cover property (o_cache_req && o_cache_action == ACT_HIT_INV);
endmodule : ivdec_props

bind ivdec_decoder ivdec_props u_props (.*);
`default_nettype wire

// *** bench/testbench.sv ***
// self-checking bench for the isa variant decoder
`default_nettype none
module testbench
	import ivdec_pkg::*;
();
	timeunit 1ns;
	timeprecision 100ps;

	logic		i_clk = 1'b0;
	logic		i_rst_n = 1'b0;
	logic		i_valid = 1'b0;
	logic [31:0]	i_instr = 32'h0;
	logic [63:0]	i_vaddr = 64'h0;
	logic		i_sys_coproc_usable_bit = 1'b1;
	logic		i_mem_idle = 1'b1;
	logic		i_branch_taken = 1'b0;
	logic		o_ready, o_valid, o_resv_exc, o_cop_unusable;
	logic		o_cache_req, o_barrier, o_delay_slot, o_annul;
	ivdec_kind_t	o_kind;
	ivdec_cop_t	o_cop_sel;
	ivdec_target_t	o_cache_target;
	ivdec_action_t	o_cache_action;
	logic [1:0]	o_cache_way;
	logic [63:0]	o_cache_addr, va;
	logic [4:0]	o_src_reg, o_dst_reg;
	int		mismatches = 0;
	int		num_checks = 0;
	// prefetch, indexed prefetch, superscalar no-op, hazard barrier, wait
	logic [31:0] nops [5] = '{{OPC_PREFETCH_HINT_INSTR, 5'h04, 5'h01, 16'h0040},
		{OPC_COP1X, 5'h04, 5'h05, 10'h0, FN_INDEXED_PREFETCH_HINT_INSTR},
		{OPC_SPECIAL, 15'h0, SA_SUPERSCALAR_NOOP_INSTR, FN_SLL},
		{OPC_SPECIAL, 15'h0, SA_EHB, FN_SLL},
		{OPC_COP0, 1'b1, 19'h0, FN_WAIT}};
	// effective codes: three i-cache, seven d-cache, six s-cache
	logic [4:0] codes [16] = '{5'h00, 5'h08, 5'h1c, 5'h01, 5'h05, 5'h09,
		5'h11, 5'h15, 5'h19, 5'h1d, 5'h03, 5'h07, 5'h0b, 5'h13, 5'h1b, 5'h1f};
	ivdec_action_t acts [16] = '{ACT_IDX_INV, ACT_IDX_ST_TAG, ACT_IDX_ST_DATA,
		ACT_IDX_WB_INV, ACT_IDX_LD_TAG, ACT_IDX_ST_TAG, ACT_HIT_INV,
		ACT_HIT_WB_INV, ACT_IDX_LD_DATA, ACT_IDX_ST_DATA, ACT_IDX_WB_INV,
		ACT_IDX_LD_TAG, ACT_IDX_ST_TAG, ACT_HIT_WB_INV, ACT_IDX_LD_DATA,
		ACT_IDX_ST_DATA};

	ivdec_decoder u_dut (.*);

	always #2.5 i_clk = ~i_clk;

	////////////////////////////////////////////////////////////////////////
	task end_of_test;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : end_of_test

	task chk(input logic [63:0] got, input logic [63:0] exp, input string s);
		num_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[ERR] %0t %s got %0h exp %0h", $time, s, got, exp);
		end
	endtask : chk

	task chk_bit(input logic got, input logic exp, input string s);
		num_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[ERR] %0t %s got %b exp %b", $time, s, got, exp);
		end
	endtask : chk_bit

	// offer at a falling edge, hold until taken, return after the answer
	// lands; valid stays up so the caller lowers or replaces it
	task send(input logic [31:0] ins, input logic [63:0] addr);
		int n;
		i_valid = 1'b1;
		i_instr = ins;
		i_vaddr = addr;
		n = 0;
		while (o_ready !== 1'b1 && n < 100)
		begin
			@(negedge i_clk);
			n++;
		end
		@(negedge i_clk);
	endtask : send

	task res(input ivdec_kind_t k, input logic exc);
		chk_bit(o_valid, 1'b1, "valid");
		chk(64'(o_kind), 64'(k), "kind");
		chk_bit(o_resv_exc, exc, "reserved exception");
	endtask : res

	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial
	begin
		repeat (4) @(negedge i_clk);
		i_rst_n = 1'b1;
		repeat (3) @(negedge i_clk);
		chk_bit(o_ready, 1'b1, "ready after reset");
		chk(64'(o_kind), 64'(KIND_PASS), "kind after reset");
		for (int k = 0; k < 5; k++)
		begin
			send(nops[k], 64'h0);
			res(KIND_NOP, 1'b0);
			chk_bit(o_cache_req | o_barrier, 1'b0, "no-op side effect");
			chk_bit(o_ready, 1'b1, "no-op stalled");
		end
		for (int k = 0; k < 2; k++)
		begin
			send({OPC_COP0, k ? RS_WRITE_PREV_REGSET_INSTR : RS_READ_PREV_REGSET_INSTR, 5'h07, 5'h13, 11'h0},
				64'h0);
			res(KIND_REGMOVE, 1'b0);
			chk(64'(o_src_reg), 64'h07, "source reg");
			chk(64'(o_dst_reg), 64'h13, "dest reg");
			send({OPC_COP0, RS_MFMC0, 5'h00, 5'h0c, 5'h00, k[0], 5'h00},
				64'h0);
			res(KIND_EXC, 1'b1);
		end
		// barrier: bad subtype, user mode, then a real drain
		send({OPC_SPECIAL, 15'h0, 5'h04, FN_SYNC}, 64'h0);
		res(KIND_EXC, 1'b1);
		chk_bit(o_barrier | ~o_ready, 1'b0, "bad subtype stalled");
		i_sys_coproc_usable_bit = 1'b0;
		send({OPC_SPECIAL, 15'h0, SYNC_STYPE_OK, FN_SYNC}, 64'h0);
		res(KIND_EXC, 1'b0);
		chk_bit(o_cop_unusable, 1'b1, "user barrier");
		i_sys_coproc_usable_bit = 1'b1;
		i_mem_idle = 1'b0;
		send({OPC_SPECIAL, 15'h0, SYNC_STYPE_OK, FN_SYNC}, 64'h0);
		chk_bit(o_barrier, 1'b1, "barrier pulse");
		i_instr = nops[2];
		// the barrier's own valid pulse stands in the first cycle, so skip it
		repeat (3)
		begin
			@(negedge i_clk);
			chk_bit(o_ready | o_valid, 1'b0, "taken during drain");
		end
		i_mem_idle = 1'b1;
		@(negedge i_clk);
		chk_bit(o_ready, 1'b1, "ready after drain");
		send(nops[2], 64'h0);
		res(KIND_NOP, 1'b0);
		// every effective cache code, way from low address bits except hit ops, which expect way 0
		for (int k = 0; k < 16; k++)
		begin
			va = 64'h0000_00ab_cdef_0100 + 64'(k);
			send({OPC_CACHE, 5'h04, codes[k], 16'h0}, va);
			res(KIND_CACHE, 1'b0);
			chk_bit(o_cache_req, 1'b1, "cache request");
			chk(64'(o_cache_target), k < 3 ? 64'(TGT_I) : k < 10 ?
				64'(TGT_D) : 64'(TGT_S), "target");
			chk(64'(o_cache_action), 64'(acts[k]), "action");
			chk(64'(o_cache_way), (acts[k] == ACT_HIT_INV ||
				acts[k] == ACT_HIT_WB_INV) ? 64'h0 : 64'(va[1:0]), "way");
			chk(o_cache_addr, va, "cache address");
		end
		for (int k = 0; k < 2; k++)
		begin
			send({OPC_CACHE, 5'h04, k ? 5'h1e : 5'h02, 16'h0}, 64'h0);
			res(KIND_EXC, 1'b1);
			chk_bit(o_cache_req, 1'b0, "unlisted cache op");
		end
		// both coprocessors present
		send({OPC_COP1, 26'h0}, 64'h0);
		chk(64'(o_cop_sel), 64'(COP_FLOAT), "float coprocessor");
		send({OPC_COP0, 1'b1, 19'h0, 6'h02}, 64'h0);
		res(KIND_COP, 1'b0);
		chk(64'(o_cop_sel), 64'(COP_SYS), "system coprocessor");
		// likely untaken, likely taken, plain branch
		for (int k = 0; k < 3; k++)
		begin
			send({k == 2 ? OPC_BEQ : OPC_BEQL, 5'h01, 5'h02, 16'h4}, 64'h0);
			res(KIND_BRANCH, 1'b0);
			i_branch_taken = (k == 1);
			send(nops[2], 64'h0);
			chk_bit(o_delay_slot, 1'b1, "delay slot");
			chk_bit(o_annul, k == 0, "annul");
			res(KIND_NOP, 1'b0);
		end
		i_valid = 1'b0;
		@(negedge i_clk);
		end_of_test;
	end

	// watchdog well past the roughly fifty cycles the tests need
	initial
	begin
		#(5 * 3000);
		mismatches++;
		$display("[ERR] %0t watchdog expired", $time);
		end_of_test;
	end
endmodule : testbench
`default_nettype wire
